/* File: inc/bisr_cfg.svh */
// Offsets, field positions, reset values and window constants for the bridge info/status registers
`ifndef BISR_CFG_SVH
`define BISR_CFG_SVH

// ====================================================================
// Register offsets
`define BISR_OFS_CAPABILITY 12'h130
`define BISR_OFS_STATUS_CTRL 12'h134
`define BISR_OFS_IRQ_DECODE 12'h138
`define BISR_OFS_IRQ_MASK 12'h13c

// ====================================================================
// Capability word fields
`define BISR_CAP_SPEED2_BIT 0
`define BISR_CAP_ROOT_BIT 1
`define BISR_CAP_UPCFG_BIT 2
`define BISR_CAP_BUSW_LSB 16
`define BISR_CAP_BUSW_MSB 18

// ====================================================================
// Status and control fields
`define BISR_SC_BUSY_BIT 0
`define BISR_SC_GDIS_BIT 8
`define BISR_SC_CLR_OVR_BIT 16
`define BISR_SC_RO_OVR_BIT 17

// ====================================================================
// Interrupt decode fields
`define BISR_DEC_ERRMSG_MASK 32'h00000e00
`define BISR_DEC_VALID_MASK 32'h1ff30fef

// ====================================================================
// Window geometry and reset values
`define BISR_WIN_BASE_BITS 20
`define BISR_BUSW_MAX 8
`define BISR_ZERO_WORD 32'h00000000

`endif

/* File: inc/bisr_pkg.sv */
// Types shared by the bridge info/status register block
package bisr_pkg;

	// Bus request as seen by the register file
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
	} bisr_req_t;

	// Control bits decoded from the status and control word
	typedef struct packed {
		logic global_disable;
		logic clear_on_write_override;
		logic read_only_override;
	} bisr_ctrl_t;

	// Write channel handshake states
	typedef enum logic [1:0] {
		BISR_W_IDLE = 2'b00,
		BISR_W_RESP = 2'b01
	} bisr_wstate_t;

	// Read channel handshake states
	typedef enum logic [1:0] {
		BISR_R_IDLE = 2'b00,
		BISR_R_DATA = 2'b01
	} bisr_rstate_t;

endpackage

/* File: src/bisr_regs.sv */
// AXI4-Lite register bank: capability, status/control, interrupt decode and mask
`timescale 1ns/1ps
`include "bisr_cfg.svh"
// Operation
// - Capability word is read-only; static except the speed flag
// - Speed flag set when both ends support it
// - Root flag set when configured as root
// - Upconfigure flag reports width upconfigure ability
// - Bus-number width 1..8, or 0 absent
// - Window spans twenty bits plus bus width
// - Window size follows base and high parameters
// - Busy flag is read-only, always zero
// - Global disable bit 8 holds interrupt low
// - Events still set decode bits when disabled
// - Bit 16 lets writes store clear-on-write bits
// - Bit 17 is stored and read back only; no read-only field becomes writable
// - Host reaches registers over AXI4-Lite
// - Reset returns every register to default
// - Unmapped locations read zero, ignore writes
// - Writing one clears decode bits, except errors
module bisr_regs #(
	parameter logic [31:0] WINDOW_BASE_PARAM = 32'h00000000,
	parameter logic [31:0] WINDOW_HIGH_PARAM = 32'h0fffffff,
	parameter bit ROOT_PORT = 1'b0,
	parameter bit UPCONFIG_CAPABLE = 1'b0
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic SPEED2_LOCAL,
	input wire logic SPEED2_PARTNER,
	input wire logic [31:0] EVENT_SET,
	input wire logic [31:0] PROBE_ADDR,
	output logic PROBE_IN_WINDOW,
	output logic IRQ_OUT,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// ====================================================================
	// Reset synchroniser
	logic rst_meta;
	logic rst_n;

	// Two stages so release is clean to the clock
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ====================================================================
	// Window decoder
	logic [3:0] bus_width;

	bisr_window #(
		.WINDOW_BASE_PARAM(WINDOW_BASE_PARAM),
		.WINDOW_HIGH_PARAM(WINDOW_HIGH_PARAM)
	) u_window (
		.probe_addr(PROBE_ADDR),
		.bus_width(bus_width),
		.in_window(PROBE_IN_WINDOW)
	);

	// ====================================================================
	// Byte-strobe merge used by every writable register
	function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// ====================================================================
	// Write channel: address and data taken together
	bisr_pkg::bisr_wstate_t wstate;
	bisr_pkg::bisr_req_t req;
	logic wr_fire;

	assign wr_fire = (wstate == bisr_pkg::BISR_W_IDLE) && S_AXI_AWVALID && S_AXI_WVALID;
	assign S_AXI_AWREADY = wr_fire;
	assign S_AXI_WREADY = wr_fire;
	assign S_AXI_BVALID = (wstate == bisr_pkg::BISR_W_RESP);
	assign S_AXI_BRESP = 2'h0;
	assign req.wr = wr_fire;
	assign req.rd = 1'b0;
	assign req.addr = S_AXI_AWADDR;
	assign req.wdata = S_AXI_WDATA;
	assign req.strb = S_AXI_WSTRB;

	// One write outstanding; response always OKAY
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wstate <= bisr_pkg::BISR_W_IDLE;
		end else begin
			case (wstate)
				bisr_pkg::BISR_W_IDLE: begin
					if (wr_fire) begin
						wstate <= bisr_pkg::BISR_W_RESP;
					end
				end
				bisr_pkg::BISR_W_RESP: begin
					if (S_AXI_BREADY) begin
						wstate <= bisr_pkg::BISR_W_IDLE;
					end
				end
				default: begin
					wstate <= bisr_pkg::BISR_W_IDLE;
				end
			endcase
		end
	end

	// ====================================================================
	// Status and control register
	bisr_pkg::bisr_ctrl_t ctrl;
	logic [31:0] wmask;

	assign wmask = strobe_mask(req.strb);

	// Only bits 8, 16 and 17 hold state
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (req.wr && req.addr == `BISR_OFS_STATUS_CTRL) begin
			if (wmask[`BISR_SC_GDIS_BIT]) begin
				ctrl.global_disable <= req.wdata[`BISR_SC_GDIS_BIT];
			end
			if (wmask[`BISR_SC_CLR_OVR_BIT]) begin
				ctrl.clear_on_write_override <= req.wdata[`BISR_SC_CLR_OVR_BIT];
			end
			if (wmask[`BISR_SC_RO_OVR_BIT]) begin
				ctrl.read_only_override <= req.wdata[`BISR_SC_RO_OVR_BIT];
			end
		end
	end

	// ====================================================================
	// Capability word, assembled from configuration, both speed inputs and the window size
	logic [31:0] cap_word;

	// Static except the speed flag; read-only override has no target here
	always_comb begin
		cap_word = `BISR_ZERO_WORD;
		cap_word[`BISR_CAP_SPEED2_BIT] = SPEED2_LOCAL & SPEED2_PARTNER;
		cap_word[`BISR_CAP_ROOT_BIT] = ROOT_PORT;
		cap_word[`BISR_CAP_UPCFG_BIT] = UPCONFIG_CAPABLE;
		cap_word[`BISR_CAP_BUSW_MSB:`BISR_CAP_BUSW_LSB] = bus_width[2:0];
		if (bus_width == 4'(`BISR_BUSW_MAX)) begin
			cap_word[`BISR_CAP_BUSW_MSB + 1] = 1'b1;
		end
	end

	// ====================================================================
	// Interrupt decode and mask
	logic [31:0] irq_decode;
	logic [31:0] irq_mask;
	logic dec_hit;
	logic [31:0] clear_bits;

	assign dec_hit = req.wr && req.addr == `BISR_OFS_IRQ_DECODE;
	// Error-message bits need their FIFO drained first, so ones never clear them
	assign clear_bits = req.wdata & wmask & ~`BISR_DEC_ERRMSG_MASK;

	// Event sets win over any clear; disable never blocks them
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_decode <= `BISR_ZERO_WORD;
		end else if (dec_hit && ctrl.clear_on_write_override) begin
			irq_decode <= (((irq_decode & ~wmask) | (req.wdata & wmask)) | EVENT_SET) &
				`BISR_DEC_VALID_MASK;
		end else if (dec_hit) begin
			irq_decode <= ((irq_decode & ~clear_bits) | EVENT_SET) & `BISR_DEC_VALID_MASK;
		end else begin
			irq_decode <= (irq_decode | EVENT_SET) & `BISR_DEC_VALID_MASK;
		end
	end

	// Mask is plain read-write
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= `BISR_ZERO_WORD;
		end else if (req.wr && req.addr == `BISR_OFS_IRQ_MASK) begin
			irq_mask <= ((irq_mask & ~wmask) | (req.wdata & wmask)) & `BISR_DEC_VALID_MASK;
		end
	end

	// Registered so the line is glitch free
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= (|(irq_decode & irq_mask)) && !ctrl.global_disable;
		end
	end

	// ====================================================================
	// Read channel
	bisr_pkg::bisr_rstate_t rstate;
	logic [31:0] rd_word;

	assign S_AXI_ARREADY = (rstate == bisr_pkg::BISR_R_IDLE);
	assign S_AXI_RVALID = (rstate == bisr_pkg::BISR_R_DATA);
	assign S_AXI_RRESP = 2'h0;

	// Unmapped offsets read zero
	always_comb begin
		rd_word = `BISR_ZERO_WORD;
		if (S_AXI_ARADDR == `BISR_OFS_CAPABILITY) begin
			rd_word = cap_word;
		end else if (S_AXI_ARADDR == `BISR_OFS_STATUS_CTRL) begin
			rd_word[`BISR_SC_BUSY_BIT] = 1'b0;
			rd_word[`BISR_SC_GDIS_BIT] = ctrl.global_disable;
			rd_word[`BISR_SC_CLR_OVR_BIT] = ctrl.clear_on_write_override;
			rd_word[`BISR_SC_RO_OVR_BIT] = ctrl.read_only_override;
		end else if (S_AXI_ARADDR == `BISR_OFS_IRQ_DECODE) begin
			rd_word = irq_decode;
		end else if (S_AXI_ARADDR == `BISR_OFS_IRQ_MASK) begin
			rd_word = irq_mask;
		end
	end

	// Data captured at address handshake, held until taken
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rstate <= bisr_pkg::BISR_R_IDLE;
			S_AXI_RDATA <= `BISR_ZERO_WORD;
		end else begin
			case (rstate)
				bisr_pkg::BISR_R_IDLE: begin
					if (S_AXI_ARVALID) begin
						rstate <= bisr_pkg::BISR_R_DATA;
						S_AXI_RDATA <= rd_word;
					end
				end
				bisr_pkg::BISR_R_DATA: begin
					if (S_AXI_RREADY) begin
						rstate <= bisr_pkg::BISR_R_IDLE;
					end
				end
				default: begin
					rstate <= bisr_pkg::BISR_R_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: src/bisr_window.sv */
// Bus-number width and configuration window decoder derived from base and high parameters
`timescale 1ns/1ps
`include "bisr_cfg.svh"
module bisr_window #(
	parameter logic [31:0] WINDOW_BASE_PARAM = 32'h00000000,
	parameter logic [31:0] WINDOW_HIGH_PARAM = 32'h0fffffff
) (
	input wire logic [31:0] probe_addr,
	output logic [3:0] bus_width,
	output logic in_window
);
	// ====================================================================
	// Width of the span minus the fixed function/register field
	function automatic logic [3:0] span_bus_bits(input logic [31:0] span);
		logic [5:0] bits;
		logic [5:0] excess;
		bits = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (span[i]) begin
				bits = 6'(i + 1);
			end
		end
		if (bits <= 6'(`BISR_WIN_BASE_BITS)) begin
			return 4'h0;
		end
		excess = bits - 6'(`BISR_WIN_BASE_BITS);
		if (excess > 6'(`BISR_BUSW_MAX)) begin
			return 4'(`BISR_BUSW_MAX);
		end
		return excess[3:0];
	endfunction

	localparam logic [31:0] SPAN = WINDOW_HIGH_PARAM - WINDOW_BASE_PARAM;
	localparam logic [3:0] BUS_BITS = span_bus_bits(SPAN);

	// Static width; a window too small for one bus reports absent
	assign bus_width = BUS_BITS;

	// Window covers twenty bits plus the bus field
	assign in_window = (BUS_BITS != 4'h0) &&
		((probe_addr >> (`BISR_WIN_BASE_BITS + 32'(BUS_BITS))) ==
		(WINDOW_BASE_PARAM >> (`BISR_WIN_BASE_BITS + 32'(BUS_BITS))));
endmodule

/* File: test/bisr_host.sv */
// Host model driving the register bank over AXI4-Lite
`timescale 1ns/1ps
module bisr_host (
	input wire logic CORE_CLK,
	output logic [11:0] S_AXI_AWADDR,
	output logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	output logic [31:0] S_AXI_WDATA,
	output logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	output logic S_AXI_BREADY,
	output logic [11:0] S_AXI_ARADDR,
	output logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	output logic S_AXI_RREADY
);
	// Extra cycles before taking a response, so slow hosts are covered
	int lag = 0;
	int n;
	// Handshakes that never completed; the bench counts them as mismatches
	int stalls = 0;
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 60'h0;
	end
	// Write held until both readys are seen; released data is inverted
	// Readys are combinational, so they are looked at mid-cycle where settled
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		{S_AXI_AWVALID, S_AXI_WVALID} <= 2'b11;
		for (n = 0; n < 9; n++) begin
			@(negedge CORE_CLK);
			if (S_AXI_AWREADY && S_AXI_WREADY) break;
		end
		if (n == 9) stalls++;
		@(posedge CORE_CLK);
		{S_AXI_AWVALID, S_AXI_WVALID} <= 2'b00;
		S_AXI_WDATA <= ~d;
		repeat (lag) @(posedge CORE_CLK);
		S_AXI_BREADY <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(negedge CORE_CLK);
			if (S_AXI_BVALID) break;
		end
		if (n == 9) stalls++;
		@(posedge CORE_CLK);
		S_AXI_BREADY <= 1'b0;
	endtask
	// Read held until ready; data taken at the edge that completes it
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(negedge CORE_CLK);
			if (S_AXI_ARREADY) break;
		end
		if (n == 9) stalls++;
		@(posedge CORE_CLK);
		S_AXI_ARVALID <= 1'b0;
		S_AXI_ARADDR <= ~a;
		repeat (lag) @(posedge CORE_CLK);
		S_AXI_RREADY <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(negedge CORE_CLK);
			if (S_AXI_RVALID) break;
		end
		if (n == 9) stalls++;
		@(posedge CORE_CLK);
		d = S_AXI_RDATA;
		S_AXI_RREADY <= 1'b0;
	endtask
endmodule

/* File: test/bisr_regs_chk.sv */
// Port assertions for the bridge info/status register bank
`timescale 1ns/1ps
module bisr_chk #(
	parameter logic [31:0] WINDOW_BASE_PARAM = 32'h00000000,
	parameter logic [31:0] WINDOW_HIGH_PARAM = 32'h0fffffff,
	parameter bit ROOT_PORT = 1'b0,
	parameter bit UPCONFIG_CAPABLE = 1'b0
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic [31:0] PROBE_ADDR,
	input wire logic PROBE_IN_WINDOW,
	input wire logic IRQ_OUT,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// ==========================================
	// Read address in flight
	logic [11:0] ra;
	logic gdis;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN)
			ra <= 12'h000;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			ra <= S_AXI_ARADDR;
	end
	// Shadow of global disable; only a write that strobes byte 1 moves it
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN)
			gdis <= 1'b0;
		else if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_AWADDR == 12'h134 && S_AXI_WSTRB[1])
			gdis <= S_AXI_WDATA[8];
	end
	// ==========================================
	// Properties
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	sequence s_aw;
		S_AXI_AWVALID && S_AXI_AWREADY;
	endsequence
	sequence s_ar;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	a_write_resp: assert property (s_aw |=> S_AXI_BVALID && S_AXI_BRESP == 2'b00)
		else $error("write response missing");
	a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	a_read_resp: assert property (s_ar |=> S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_RRESP == 2'b00)
		else $error("read response missing");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped or changed");
	a_cap_fields: assert property (S_AXI_RVALID && ra == 12'h130 |->
		S_AXI_RDATA[2:1] == {UPCONFIG_CAPABLE, ROOT_PORT} &&
		S_AXI_RDATA[15:3] == 13'h0000 &&
		S_AXI_RDATA[31:20] == 12'h000)
		else $error("capability fields wrong");
	a_status_bits: assert property (S_AXI_RVALID && ra == 12'h134 |->
		(S_AXI_RDATA & 32'hfffcfeff) == 32'h00000000 && S_AXI_RDATA[8] == gdis)
		else $error("status word wrong");
	a_unmapped_zero: assert property (S_AXI_RVALID && ra >= 12'h160 && ra <= 12'h1ff |->
		S_AXI_RDATA == 32'h00000000)
		else $error("unmapped read not zero");
	a_window_dec: assert property (PROBE_IN_WINDOW ==
		(PROBE_ADDR >= WINDOW_BASE_PARAM && PROBE_ADDR <= WINDOW_HIGH_PARAM))
		else $error("window decode wrong");
	a_irq_quiet: assert property (gdis && $past(gdis) |-> !IRQ_OUT)
		else $error("interrupt while disabled");
endmodule
bind bisr_regs bisr_chk #(.WINDOW_BASE_PARAM(WINDOW_BASE_PARAM), .WINDOW_HIGH_PARAM(WINDOW_HIGH_PARAM),
	.ROOT_PORT(ROOT_PORT), .UPCONFIG_CAPABLE(UPCONFIG_CAPABLE)) i_bisr_chk (.*);

/* File: test/tb_top.sv */
// Self-checking bench for the bridge info/status register bank
`timescale 1ns/1ps
module tb_top;
	logic CORE_CLK, RESETN, SPEED2_LOCAL, SPEED2_PARTNER, PROBE_IN_WINDOW, IRQ_OUT;
	logic [31:0] EVENT_SET, PROBE_ADDR, S_AXI_WDATA, S_AXI_RDATA, d, wd;
	logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR, a;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [31:0] seed = 32'd85067;
	int err_total = 0;
	int compares = 0;
	int i;
	bisr_regs #(.ROOT_PORT(1'b1), .UPCONFIG_CAPABLE(1'b1)) i_bisr_regs (.*);
	bisr_host i_bisr_host (.*);
	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Default window spans 28 bits, so the bus-number width reads 8
	function automatic logic [31:0] exp_cap(input logic l, input logic p);
		return {12'h000, 4'h8, 13'h0000, 1'b1, 1'b1, l & p};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [31:0] v);
		@(posedge CORE_CLK);
		EVENT_SET <= v;
		@(posedge CORE_CLK);
		EVENT_SET <= 32'h00000000;
		// Line is registered; look mid-cycle once it has settled
		@(posedge CORE_CLK);
		@(negedge CORE_CLK);
	endtask
	task automatic complete_run();
		err_total += i_bisr_host.stalls;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		err_total++;
		complete_run();
	end
	// ==========================================
	// Scenarios
	initial begin
		{RESETN, SPEED2_LOCAL, SPEED2_PARTNER, EVENT_SET, PROBE_ADDR} = 67'h0;
		repeat (3) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		repeat (4) @(posedge CORE_CLK);
		// Everything writable comes out of reset at zero
		for (a = 12'h134; a < 12'h140; a += 12'h004) begin
			i_bisr_host.rd(a, d);
			chk(d, 32'h00000000);
		end
		// Capability ignores writes and follows both speed inputs
		for (i = 0; i < 4; i++) begin
			SPEED2_LOCAL <= i[0];
			SPEED2_PARTNER <= i[1];
			i_bisr_host.wr(12'h130, rnd(), 4'hf);
			i_bisr_host.rd(12'h130, d);
			chk(d, exp_cap(i[0], i[1]));
		end
		// Status word keeps only its three writable bits
		for (i = 0; i < 8; i++) begin
			wd = rnd();
			i_bisr_host.lag = wd[1:0];
			i_bisr_host.wr(12'h134, wd, 4'hf);
			i_bisr_host.rd(12'h134, d);
			chk(d, wd & 32'h00030100);
		end
		i_bisr_host.wr(12'h134, 32'h00000000, 4'hf);
		i_bisr_host.wr(12'h134, 32'hffffffff, 4'h2);
		i_bisr_host.rd(12'h134, d);
		chk(d, 32'h00000100);
		// Unmapped places read zero whatever was written
		for (a = 12'h160; a < 12'h200; a += 12'h024) begin
			i_bisr_host.wr(a, rnd(), 4'hf);
			i_bisr_host.rd(a, d);
			chk(d, 32'h00000000);
		end
		// Window decode at its top edge and at random
		for (i = 0; i < 12; i++) begin
			PROBE_ADDR <= (i == 0) ? 32'h0fffffff : (i == 1) ? 32'h10000000 : rnd() >> (i % 5);
			@(posedge CORE_CLK);
			chk({31'h0, PROBE_IN_WINDOW}, {31'h0, PROBE_ADDR < 32'h10000000});
		end
		// Interrupt line, global disable, clear-on-write and its override
		i_bisr_host.wr(12'h134, 32'h00000000, 4'hf);
		i_bisr_host.wr(12'h13c, 32'h1ff30fef, 4'hf);
		pulse(32'h00000e05);
		chk({31'h0, IRQ_OUT}, 32'h00000001);
		i_bisr_host.wr(12'h134, 32'h00000100, 4'hf);
		pulse(32'h00100000);
		chk({31'h0, IRQ_OUT}, 32'h00000000);
		i_bisr_host.rd(12'h138, d);
		chk(d, 32'h00100e05);
		i_bisr_host.wr(12'h138, 32'h00100e05, 4'hf);
		i_bisr_host.rd(12'h138, d);
		chk(d, 32'h00000e00);
		i_bisr_host.wr(12'h134, 32'h00010000, 4'hf);
		i_bisr_host.wr(12'h138, 32'h00000000, 4'hf);
		i_bisr_host.rd(12'h138, d);
		chk(d, 32'h00000000);
		repeat (2) @(negedge CORE_CLK);
		chk({31'h0, IRQ_OUT}, 32'h00000000);
		// Mid-run reset with state loaded: line drops, registers back to zero
		i_bisr_host.wr(12'h134, 32'h00030000, 4'hf);
		pulse(32'h00000001);
		chk({31'h0, IRQ_OUT}, 32'h00000001);
		@(posedge CORE_CLK);
		RESETN <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		chk({31'h0, IRQ_OUT}, 32'h00000000);
		repeat (4) @(posedge CORE_CLK);
		for (a = 12'h134; a < 12'h140; a += 12'h004) begin
			i_bisr_host.rd(a, d);
			chk(d, 32'h00000000);
		end
		complete_run();
	end
endmodule
